// *** video_in_pkg.sv ***
package video_in_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] COUNT_OFFSET = 12'h008;

    // Status field positions
    localparam int STAT_PAL_BIT = 0;
    localparam int STAT_FIELD_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_FRAME_BIT = 3;

    // ----------------------------------------------------------------
    // Line standards, input widths and panel widths
    // ----------------------------------------------------------------
    localparam logic [9:0] LINES_PAL = 10'h120;
    localparam logic [9:0] LINES_NTSC = 10'h0f0;
    localparam logic [9:0] WIDTH_320 = 10'h140;
    localparam logic [9:0] WIDTH_352 = 10'h160;
    localparam logic [9:0] WIDTH_360 = 10'h168;
    localparam logic [9:0] PANEL_502 = 10'h1f6;
    localparam logic [9:0] PANEL_640 = 10'h280;
    localparam logic [9:0] PANEL_720 = 10'h2d0;
    localparam logic [9:0] PANEL_960 = 10'h3c0;
    localparam logic [9:0] COUNT_MAX = 10'h3ff;

    // Control register layout, bit 31 downward
    typedef struct packed {
        logic [22:0] unused;
        logic [1:0] panel_sel;
        logic std_pal;
        logic hflip;
        logic field_alt;
        logic auto_en;
        logic [1:0] width_sel;
        logic scaled;
    } ctrl_type;

    localparam ctrl_type CTRL_RESET = '0;

    // One captured dot or triplet
    typedef struct packed {
        logic [23:0] data;
        logic [9:0] pos;
        logic [8:0] line;
        logic field;
        logic scaled;
    } pix_type;

    // Line capture states, Gray along the path
    typedef enum logic [1:0] {
        L_IDLE = 2'b00,
        L_ACTIVE = 2'b01,
        L_FULL = 2'b11
    } line_state_type;

endpackage

// *** pix_buffer.sv ***
`timescale 1ns/1ps

module pix_buffer #(
    parameter int WIDTH = 46,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CW-1:0] count;
    } buf_state_type;

    buf_state_type s;
    buf_state_type next_s;
    logic do_push;
    logic do_pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (s.count != CW'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rd];
    assign do_push = in_valid & in_ready;
    assign do_pop = out_valid & out_ready;

    // Pointer and count update
    always_comb begin
        next_s = s;
        if (do_push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
        end
        if (do_pop) begin
            next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
        end
        next_s.count = s.count + CW'(do_push) - CW'(do_pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

// *** video_in_front_end.sv ***
`timescale 1ns/1ps

module video_in_front_end #(
    parameter logic [9:0] DIRECT_DOTS = video_in_pkg::PANEL_960
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Video pins from the host controller
    input wire logic dot_clock,
    input wire logic hsync_n,
    input wire logic vsync_n,
    input wire logic [7:0] dot_data,
    // Captured pixel stream
    output logic pix_valid,
    input wire logic pix_ready,
    output video_in_pkg::pix_type pix
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [9:0] width_of(input logic [1:0] sel);
        case (sel)
            2'h1: width_of = video_in_pkg::WIDTH_352;
            2'h2: width_of = video_in_pkg::WIDTH_360;
            default: width_of = video_in_pkg::WIDTH_320;
        endcase
    endfunction

    function automatic logic [9:0] panel_of(input logic [1:0] sel);
        case (sel)
            2'h1: panel_of = video_in_pkg::PANEL_640;
            2'h2: panel_of = video_in_pkg::PANEL_720;
            2'h3: panel_of = video_in_pkg::PANEL_960;
            default: panel_of = video_in_pkg::PANEL_502;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic dot_clock_s1;
        logic dot_clock_s2;
        logic dot_clock_d;
        logic hs_s1;
        logic hs_s2;
        logic hs_d;
        logic vs_s1;
        logic vs_s2;
        logic vs_d;
        logic [7:0] dat_s1;
        logic [7:0] dat_s2;
        video_in_pkg::ctrl_type ctrl;
        logic pal;
        logic field;
        logic overflow;
        logic frame_seen;
        logic [9:0] hcount;
        logic [9:0] last_count;
        logic [8:0] line;
        logic [9:0] idx;
        logic [9:0] dot;
        logic [10:0] rem;
        logic [1:0] phase;
        logic [15:0] part;
        video_in_pkg::line_state_type lstate;
    } fe_state_type;

    fe_state_type s;
    fe_state_type next_s;
    logic dot_clock_rise;
    logic hs_fall;
    logic vs_fall;
    logic push;
    logic push_ready;
    video_in_pkg::pix_type push_data;
    logic [9:0] in_width;
    logic [9:0] panel;
    logic [9:0] act_lines;
    logic wr_en;
    logic rd_en;
    logic mapped;

    // Edges come only from the second and third sampling stages
    assign dot_clock_rise = s.dot_clock_s2 & ~s.dot_clock_d;
    assign hs_fall = ~s.hs_s2 & s.hs_d;
    assign vs_fall = ~s.vs_s2 & s.vs_d;
    assign in_width = width_of(s.ctrl.width_sel);
    assign panel = panel_of(s.ctrl.panel_sel);
    assign act_lines = s.pal ? video_in_pkg::LINES_PAL : video_in_pkg::LINES_NTSC;

    // ----------------------------------------------------------------
    // APB decode, zero wait states
    // ----------------------------------------------------------------
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~pwrite;
    assign mapped = (paddr == video_in_pkg::CTRL_OFFSET) | (paddr == video_in_pkg::STATUS_OFFSET)
        | (paddr == video_in_pkg::COUNT_OFFSET);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Read mux over register flops; unmapped reads return zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en && paddr == video_in_pkg::CTRL_OFFSET) begin
            prdata = s.ctrl;
        end else if (rd_en && paddr == video_in_pkg::STATUS_OFFSET) begin
            prdata[video_in_pkg::STAT_PAL_BIT] = s.pal;
            prdata[video_in_pkg::STAT_FIELD_BIT] = s.field;
            prdata[video_in_pkg::STAT_OVF_BIT] = s.overflow;
            prdata[video_in_pkg::STAT_FRAME_BIT] = s.frame_seen;
        end else if (rd_en && paddr == video_in_pkg::COUNT_OFFSET) begin
            prdata[9:0] = s.last_count;
        end
    end

    // ----------------------------------------------------------------
    // Capture and detection
    // ----------------------------------------------------------------
    always_comb begin
        logic [10:0] sum;
        logic [1:0] step;
        sum = '0;
        step = '0;
        next_s = s;
        push = 1'b0;
        push_data = '0;
        // Two-stage sampling of every pin before use
        next_s.dot_clock_s1 = dot_clock;
        next_s.dot_clock_s2 = s.dot_clock_s1;
        next_s.dot_clock_d = s.dot_clock_s2;
        next_s.hs_s1 = hsync_n;
        next_s.hs_s2 = s.hs_s1;
        next_s.hs_d = s.hs_s2;
        next_s.vs_s1 = vsync_n;
        next_s.vs_s2 = s.vs_s1;
        next_s.vs_d = s.vs_s2;
        next_s.dat_s1 = dot_data;
        next_s.dat_s2 = s.dat_s1;

        // Software writes; status write-one clears overflow
        if (wr_en && paddr == video_in_pkg::CTRL_OFFSET) begin
            next_s.ctrl = pwdata;
            next_s.ctrl.unused = '0;
        end
        if (wr_en && paddr == video_in_pkg::STATUS_OFFSET && pwdata[video_in_pkg::STAT_OVF_BIT]) begin
            next_s.overflow = 1'b0;
        end

        if (vs_fall) begin
            next_s.last_count = s.hcount;
            next_s.hcount = '0;
            next_s.line = '0;
            next_s.lstate = video_in_pkg::L_IDLE;
            next_s.frame_seen = 1'b1;
            next_s.field = s.ctrl.field_alt ? ~s.field : 1'b0;
            if (s.ctrl.scaled && s.ctrl.auto_en) begin
                if (s.hcount > video_in_pkg::LINES_PAL) begin
                    next_s.pal = 1'b1;
                end else if (s.hcount < video_in_pkg::LINES_PAL) begin
                    next_s.pal = 1'b0;
                end
            end else begin
                next_s.pal = s.ctrl.std_pal;
            end
        end else if (hs_fall) begin
            // Saturate so a missing frame sync cannot wrap the count
            if (s.hcount != video_in_pkg::COUNT_MAX) begin
                next_s.hcount = s.hcount + 10'h001;
            end
            if (s.lstate != video_in_pkg::L_IDLE) begin
                next_s.line = s.line + 9'h001;
            end
            next_s.lstate = video_in_pkg::L_ACTIVE;
            next_s.idx = '0;
            next_s.dot = '0;
            next_s.rem = '0;
            next_s.phase = '0;
        end else if (dot_clock_rise && s.hs_s2 && s.lstate == video_in_pkg::L_ACTIVE) begin
            if (!s.ctrl.scaled) begin
                // Direct: the host already ordered dots for this line
                push = 1'b1;
                push_data.data = {16'h0000, s.dat_s2};
                push_data.pos = s.idx;
                next_s.idx = s.idx + 10'h001;
                if (s.idx == DIRECT_DOTS - 10'h001) begin
                    next_s.lstate = video_in_pkg::L_FULL;
                end
            end else if ({1'b0, s.line} < act_lines) begin
                // Scaled: assemble R, G, B bytes into a triplet
                case (s.phase)
                    2'h0: begin
                        next_s.part[15:8] = s.dat_s2;
                        next_s.phase = 2'h1;
                    end
                    2'h1: begin
                        next_s.part[7:0] = s.dat_s2;
                        next_s.phase = 2'h2;
                    end
                    default: begin
                        push = 1'b1;
                        push_data.data = {s.part, s.dat_s2};
                        push_data.pos = s.ctrl.hflip ? panel - 10'h001 - s.dot : s.dot;
                        // Remainder stepping spreads triplets over the panel, no divider needed
                        sum = s.rem + {1'b0, panel};
                        if (sum >= 11'(3) * {1'b0, in_width}) begin
                            step = 2'h3;
                        end else if (sum >= 11'(2) * {1'b0, in_width}) begin
                            step = 2'h2;
                        end else if (sum >= {1'b0, in_width}) begin
                            step = 2'h1;
                        end
                        next_s.rem = sum - 11'(step) * {1'b0, in_width};
                        next_s.dot = s.dot + 10'(step);
                        next_s.idx = s.idx + 10'h001;
                        next_s.phase = 2'h0;
                        if (s.idx == in_width - 10'h001) begin
                            next_s.lstate = video_in_pkg::L_FULL;
                        end
                    end
                endcase
            end
        end
        push_data.line = s.line;
        push_data.field = s.field;
        push_data.scaled = s.ctrl.scaled;
        // A dot arriving into a full buffer is lost; flag wins over clear
        if (push && !push_ready) begin
            next_s.overflow = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Output buffer absorbs short receiver stalls
    // ----------------------------------------------------------------
    pix_buffer #(
        .WIDTH($bits(video_in_pkg::pix_type)),
        .DEPTH(2)
    ) i_pix_buffer (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data(pix)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pal_select: assert property (vs_fall && s.ctrl.scaled && s.ctrl.auto_en
        && s.hcount > video_in_pkg::LINES_PAL |=> s.pal)
        else $error("pal not selected above 288 syncs");
    a_ntsc_select: assert property (vs_fall && s.ctrl.scaled && s.ctrl.auto_en
        && s.hcount < video_in_pkg::LINES_PAL |=> !s.pal)
        else $error("ntsc not selected below 288 syncs");
    a_equal_keep: assert property (vs_fall && s.ctrl.scaled && s.ctrl.auto_en
        && s.hcount == video_in_pkg::LINES_PAL |=> $stable(s.pal))
        else $error("standard changed at exactly 288 syncs");
    a_auto_scaled_only: assert property (vs_fall && !s.ctrl.scaled |=> s.pal == $past(s.ctrl.std_pal))
        else $error("auto-detect acted in direct format");
    a_field_single: assert property (vs_fall && !s.ctrl.field_alt |=> !s.field)
        else $error("field moved in single-field mode");
    a_field_alt: assert property (vs_fall && s.ctrl.field_alt |=> s.field != $past(s.field))
        else $error("field did not alternate");
    a_direct_dot: assert property (push && !s.ctrl.scaled |-> dot_clock_rise && s.idx < DIRECT_DOTS)
        else $error("direct dot without dot clock rise");
    a_scaled_width: assert property (push && s.ctrl.scaled |-> s.idx < in_width
        && push_data.pos < panel && {1'b0, s.line} < act_lines)
        else $error("scaled triplet outside window");
    // A stalled receiver must see the same word until it takes it
    a_stall_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix))
        else $error("pixel word changed while stalled");
    a_triplet_gap: assert property (push && s.ctrl.scaled |=> !push [*2])
        else $error("scaled triplets too close");

    c_pal_seen: cover property (vs_fall && s.ctrl.auto_en ##1 s.pal);
    c_ntsc_seen: cover property (s.pal ##1 !s.pal);
    c_scaled_push: cover property (push && s.ctrl.scaled && s.ctrl.hflip);
    c_overflow: cover property (push && !push_ready);

endmodule

// *** video_host_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host video controller: dot clock, syncs and dot bytes
// ----------------------------------------------------------------
module video_host_model (
    // Video pins towards the front end
    output logic dot_clock,
    output logic hsync_n,
    output logic vsync_n,
    output logic [7:0] dot_data
);
    // Idle pins: syncs inactive high, dot clock parked low
    initial begin
        dot_clock = 1'b0;
        hsync_n = 1'b1;
        vsync_n = 1'b1;
        dot_data = 8'h00;
    end

    // One byte per rising dot clock edge, 125 ns period, clock stands still afterwards
    task automatic dots(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            dot_data = b + 8'(i);
            #62.5 dot_clock = 1'b1;
            #62.5 dot_clock = 1'b0;
        end
        // Released bus shows the inverse so a stale byte cannot pass
        dot_data = ~dot_data;
    endtask

    // Short line sync pulse, long enough for the two-flop sampler
    task automatic hsync();
        hsync_n = 1'b0;
        #50 hsync_n = 1'b1;
        #50;
    endtask

    // Field boundary; the bench decides odd/even or single field
    task automatic vsync();
        vsync_n = 1'b0;
        #100 vsync_n = 1'b1;
        #100;
    endtask
endmodule

// *** video_in_front_end_tb.sv ***
`timescale 1ns/1ps

module video_in_front_end_tb;
    // ----------------------------------------------------------------
    // Signals and bench state
    // ----------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pix_ready, seeded, pready, pslverr, pix_valid, err, stall;
    logic dot_clock, hsync_n, vsync_n, exp_pal, exp_field;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] dot_data;
    logic [9:0] panel, width;
    video_in_pkg::pix_type pix, exp_pix;
    video_in_pkg::pix_type exp_q[$];
    video_in_pkg::ctrl_type ctrl, c;
    int n_errors, n_tests, hc;
    logic [9:0] panels[4] = '{video_in_pkg::PANEL_502, video_in_pkg::PANEL_640,
                              video_in_pkg::PANEL_720, video_in_pkg::PANEL_960};
    logic [9:0] widths[4] = '{video_in_pkg::WIDTH_320, video_in_pkg::WIDTH_352,
                              video_in_pkg::WIDTH_360, video_in_pkg::WIDTH_320};
    int auto_n[4] = '{289, 288, 287, 288};

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Short direct line limit keeps the full-line case quick
    video_in_front_end #(.DIRECT_DOTS(10'h008)) i_video_in_front_end (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dot_clock(dot_clock), .hsync_n(hsync_n), .vsync_n(vsync_n), .dot_data(dot_data),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix(pix));

    video_host_model i_video_host_model (
        .dot_clock(dot_clock), .hsync_n(hsync_n), .vsync_n(vsync_n), .dot_data(dot_data));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [45:0] exp, input logic [45:0] seen);
        n_tests++;
        if (exp !== seen) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // APB master: hold the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input video_in_pkg::ctrl_type cc);
        ctrl = cc;
        panel = panels[cc.panel_sel];
        width = widths[cc.width_sel];
        apb(1'b1, video_in_pkg::CTRL_OFFSET, cc);
    endtask

    task automatic hs(input int n);
        repeat (n) begin
            hc++;
            i_video_host_model.hsync();
        end
    endtask

    // Frame boundary: predict standard and field as the front end should
    task automatic vs();
        if (ctrl.scaled && ctrl.auto_en) begin
            if (hc > 288) exp_pal = 1'b1;
            else if (hc < 288) exp_pal = 1'b0;
        end else exp_pal = ctrl.std_pal;
        exp_field = ctrl.field_alt ? ~exp_field : 1'b0;
        hc = 0;
        i_video_host_model.vsync();
    endtask

    // One line of n bytes; expected words noted before the host sends them
    task automatic line(input int n, input logic [7:0] b);
        int lim;
        hs(1);
        lim = ctrl.scaled ? int'(width) : 8;
        for (int i = 0; i < (ctrl.scaled ? n / 3 : n) && i < lim; i++) begin
            exp_pix.line = 9'(hc - 1);
            exp_pix.field = exp_field;
            exp_pix.scaled = ctrl.scaled;
            if (ctrl.scaled) begin
                exp_pix.data = {b + 8'(3 * i), b + 8'(3 * i + 1), b + 8'(3 * i + 2)};
                exp_pix.pos = 10'((i * int'(panel)) / int'(width));
                if (ctrl.hflip) exp_pix.pos = panel - 10'h001 - exp_pix.pos;
            end else begin
                exp_pix.data = {16'h0000, b + 8'(i)};
                exp_pix.pos = 10'(i);
            end
            exp_q.push_back(exp_pix);
        end
        i_video_host_model.dots(n, b);
    endtask

    // One sync-count period, then standard and count read back
    task automatic af(input video_in_pkg::ctrl_type cc, input int n);
        int total;
        cfg(cc);
        hs(n);
        total = hc;
        vs();
        apb(1'b0, video_in_pkg::STATUS_OFFSET, 32'h0000_0000);
        chk("pal", rd[video_in_pkg::STAT_PAL_BIT], exp_pal);
        chk("status", rd[3:1], {1'b1, 1'b0, exp_field});
        apb(1'b0, video_in_pkg::COUNT_OFFSET, 32'h0000_0000);
        chk("count", rd, 32'(total));
    endtask

    task automatic summarize();
        $display("Checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Sink stalls at random once the seed is set
    always @(posedge pclk) pix_ready <= stall ? 1'b0 : seeded ? ($urandom % 4 != 0) : 1'b1;

    // Output watcher: each accepted word against the oldest note
    always @(posedge pclk) begin
        if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("pix extra", 46'h0, pix);
            else chk("pix", exp_q.pop_front(), pix);
        end
    end

    // Watchdog well beyond the expected run of about 300 us
    initial begin
        #1_000_000;
        n_errors++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, presetn, seeded, stall} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pix_ready = 1'b1;
        ctrl = video_in_pkg::CTRL_RESET;
        {exp_pal, exp_field} = '0;
        {hc, n_errors, n_tests} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(66987));
        seeded = 1'b1;
        // Reset values, reserved control bits, unmapped address
        for (int r = 0; r < 3; r++) begin
            apb(1'b0, 12'(4 * r), 32'h0000_0000);
            chk("reset value", rd, 32'h0000_0000);
        end
        apb(1'b1, video_in_pkg::CTRL_OFFSET, 32'hffff_ffff);
        apb(1'b0, video_in_pkg::CTRL_OFFSET, 32'h0000_0000);
        chk("ctrl mask", rd, 32'h0000_01ff);
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        chk("unmapped err", err, 1'b1);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk("unmapped data", {err, rd}, {1'b1, 32'h0000_0000});
        // Direct dots, alternating fields, stray dots before first sync, over-long lines
        c = video_in_pkg::CTRL_RESET;
        c.field_alt = 1'b1;
        cfg(c);
        vs();
        i_video_host_model.dots(3, 8'h5a);
        line(10, 8'($urandom));
        line(7, 8'($urandom));
        vs();
        line(10, 8'($urandom));
        // Receiver stalled: two words kept, later dots lost and flagged
        while (exp_q.size() != 0) @(posedge pclk);
        stall = 1'b1;
        line(2, 8'h30);
        i_video_host_model.dots(2, 8'h40);
        apb(1'b0, video_in_pkg::STATUS_OFFSET, 32'h0000_0000);
        chk("overflow", rd[video_in_pkg::STAT_OVF_BIT], 1'b1);
        apb(1'b1, video_in_pkg::STATUS_OFFSET, 32'h0000_0004);
        stall = 1'b0;
        apb(1'b0, video_in_pkg::STATUS_OFFSET, 32'h0000_0000);
        chk("overflow clear", rd[video_in_pkg::STAT_OVF_BIT], 1'b0);
        // Scaled triplets over every width and panel, random flip
        for (int p = 0; p < 4; p++) begin
            for (int w = 0; w < 4; w++) begin
                c = video_in_pkg::CTRL_RESET;
                c.scaled = 1'b1;
                c.width_sel = 2'(w);
                c.panel_sel = 2'(p);
                c.hflip = 1'($urandom);
                cfg(c);
                vs();
                line(12, 8'($urandom));
            end
        end
        // Full scaled line plus two extra triplets
        c.width_sel = 2'h0;
        cfg(c);
        vs();
        line(966, 8'($urandom));
        // Auto-detection sequence, then auto ignored in direct mode
        c = video_in_pkg::CTRL_RESET;
        c.scaled = 1'b1;
        c.auto_en = 1'b1;
        // Close the last frame so the first count starts from zero
        vs();
        for (int k = 0; k < 4; k++) af(c, auto_n[k]);
        c.scaled = 1'b0;
        c.std_pal = 1'b1;
        af(c, 287);
        for (int t = 0; t < 2000 && exp_q.size() != 0; t++) @(posedge pclk);
        chk("words left", 32'(exp_q.size()), 32'h0000_0000);
        summarize();
    end
endmodule
